// File: hdl/ltw_lite_timer.sv
/*
 * Timebase, watchdog and 8-bit input capture timer with an AXI4-Lite register slave.
 * Assumes clk_i is the oscillator clock, that the CPU core reports halt and wake events on this clock,
 * and that watchdog_reset_o is fed into the chip reset tree by the surrounding logic.
 */
// Implementation choices: register access over AXI4-Lite and the register addresses.
module ltw_lite_timer (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic clk_en_i,
   input wire ltw_pkg::ltw_axi_req_t axi_req_i,
   output ltw_pkg::ltw_axi_rsp_t axi_rsp_o,
   input wire logic capture_input_pin_i,
   input wire logic halt_i,
   input wire logic ext_wake_i,
   input wire logic cpu_irq_mask_i,
   input wire logic hw_watchdog_opt_i,
   input wire logic reset_on_halt_opt_i,
   input wire logic wake_delay_long_i,
   output logic tb_irq_o,
   output logic ic_irq_o,
   output logic watchdog_reset_o
);

   // ==========================================================================
   // Address decode, shared by the read and write paths.
   function automatic ltw_pkg::ltw_sel_t ltw_decode(input logic [ltw_pkg::ADDR_W-1:0] addr);
      ltw_pkg::ltw_sel_t sel;
      sel = ltw_pkg::LTW_SEL_NONE;
      if (addr == ltw_pkg::CSR_ADDR) begin
         sel = ltw_pkg::LTW_SEL_CSR;
      end else if (addr == ltw_pkg::ICR_ADDR) begin
         sel = ltw_pkg::LTW_SEL_ICR;
      end
      return sel;
   endfunction : ltw_decode

   // Reset image: ready to accept on both bus paths, everything else cleared.
   localparam ltw_pkg::ltw_axi_rsp_t RSP_RESET = '{awready: 1'b1, wready: 1'b1, arready: 1'b1, default: '0};
   localparam ltw_pkg::ltw_state_t STATE_RESET = '{bus: '{rsp: RSP_RESET, default: '0}, default: '0};

   ltw_pkg::ltw_state_t s;
   ltw_pkg::ltw_state_t next_s;

   logic counting;
   logic overflow;
   logic tb_event;
   logic period_end;
   logic pin_edge;
   logic capture_take;
   logic wdg_active;
   logic do_write;
   logic csr_write;
   logic csr_read;
   logic icr_read;
   logic force_reset;
   logic halt_reset;
   logic wdg_trigger;
   ltw_pkg::ltw_sel_t wsel;
   ltw_pkg::ltw_sel_t rsel;

   // ==========================================================================
   // Event decode from the current state.
   // The counter runs only while the oscillator is running and not in the wake-up delay.
   assign counting = !s.tmr.halted && !s.tmr.wake_wait;
   assign overflow = counting && (s.tmr.count == ltw_pkg::COUNT_WRAP);
   // Double period takes every second overflow.
   assign tb_event = overflow && (!s.tmr.period_double_select || s.tmr.tb_half);
   // Watchdog period is two overflows, counted from chip reset.
   assign period_end = overflow && s.tmr.wdg_half;
   // Edge is accepted only once the second and third stages agree on a new level.
   assign pin_edge = (s.pin_sync[1] == s.pin_sync[2]) && (s.pin_sync[2] != s.pin_level);
   // The capture path sleeps with the oscillator in halt.
   assign capture_take = pin_edge && !s.tmr.capture_flag && !s.tmr.halted;
   assign wdg_active = hw_watchdog_opt_i || s.tmr.watchdog_enable_bit;
   assign wsel = ltw_decode(s.bus.awaddr);
   assign rsel = ltw_decode(axi_req_i.araddr);
   assign do_write = s.bus.aw_held && s.bus.w_held && !s.bus.rsp.bvalid;
   assign csr_write = do_write && s.bus.wstrb0 && (wsel == ltw_pkg::LTW_SEL_CSR);
   assign csr_read = axi_req_i.arvalid && s.bus.rsp.arready && (rsel == ltw_pkg::LTW_SEL_CSR);
   assign icr_read = axi_req_i.arvalid && s.bus.rsp.arready && (rsel == ltw_pkg::LTW_SEL_ICR);
   // Forcing only works once the watchdog is running.
   assign force_reset = csr_write && s.bus.wdata[ltw_pkg::BIT_WATCHDOG_RESET_FLAG] && wdg_active;
   assign halt_reset = halt_i && reset_on_halt_opt_i && !s.tmr.halted;
   // A period already run out before enabling fires as soon as the watchdog is active.
   // With the oscillator stopped nothing may reset, the halt reset included; a stale expiry waits for the wake-up.
   assign wdg_trigger = halt_reset || (!s.tmr.halted && (force_reset ||
                        (wdg_active && (s.tmr.expired || (period_end && !s.tmr.watchdog_refresh_bit)))));

   // ==========================================================================
   // Next-state logic for the whole block.
   always_comb begin
      next_s = s;

      // Bus write address and data are taken in either order and held until the response.
      if (axi_req_i.awvalid && s.bus.rsp.awready) begin
         next_s.bus.aw_held = 1'b1;
         next_s.bus.rsp.awready = 1'b0;
         next_s.bus.awaddr = axi_req_i.awaddr;
      end
      if (axi_req_i.wvalid && s.bus.rsp.wready) begin
         next_s.bus.w_held = 1'b1;
         next_s.bus.rsp.wready = 1'b0;
         next_s.bus.wdata = axi_req_i.wdata[7:0];
         next_s.bus.wstrb0 = axi_req_i.wstrb[0];
      end
      if (do_write) begin
         next_s.bus.aw_held = 1'b0;
         next_s.bus.w_held = 1'b0;
         next_s.bus.rsp.bvalid = 1'b1;
         next_s.bus.rsp.bresp = (wsel == ltw_pkg::LTW_SEL_NONE) ? ltw_pkg::RESP_SLVERR : ltw_pkg::RESP_OKAY;
      end
      if (s.bus.rsp.bvalid && axi_req_i.bready) begin
         next_s.bus.rsp.bvalid = 1'b0;
         next_s.bus.rsp.awready = 1'b1;
         next_s.bus.rsp.wready = 1'b1;
      end

      // Read data is sampled from the state as the address is taken.
      if (axi_req_i.arvalid && s.bus.rsp.arready) begin
         next_s.bus.rsp.arready = 1'b0;
         next_s.bus.rsp.rvalid = 1'b1;
         next_s.bus.rsp.rresp = ltw_pkg::RESP_OKAY;
         next_s.bus.rsp.rdata = 32'h0000_0000;
         unique case (rsel)
            ltw_pkg::LTW_SEL_CSR: begin
               next_s.bus.rsp.rdata[7:0] = {s.tmr.capture_irq_enable, s.tmr.capture_flag,
                                            s.tmr.period_double_select, s.tmr.timebase_irq_enable,
                                            s.tmr.timebase_flag, s.tmr.watchdog_reset_flag,
                                            s.tmr.watchdog_enable_bit, s.tmr.watchdog_refresh_bit};
            end
            ltw_pkg::LTW_SEL_ICR: begin
               next_s.bus.rsp.rdata[7:0] = s.tmr.capture_value;
            end
            default: begin
               next_s.bus.rsp.rresp = ltw_pkg::RESP_SLVERR;
            end
         endcase
      end
      if (s.bus.rsp.rvalid && axi_req_i.rready) begin
         next_s.bus.rsp.rvalid = 1'b0;
         next_s.bus.rsp.arready = 1'b1;
      end

      // Pin synchroniser: the first stage feeds only the second.
      next_s.pin_sync = {s.pin_sync[1:0], capture_input_pin_i};
      if (pin_edge) begin
         next_s.pin_level = s.pin_sync[2];
      end

      // Counter and its phase bits.
      if (counting) begin
         next_s.tmr.count = overflow ? 13'h0000 : 13'(s.tmr.count + 13'h0001);
      end
      if (overflow) begin
         next_s.tmr.tb_half = !s.tmr.tb_half;
         next_s.tmr.wdg_half = !s.tmr.wdg_half;
      end

      // Software clears go first so that a hardware set in the same cycle wins.
      if (csr_read) begin
         next_s.tmr.timebase_flag = 1'b0;
         next_s.tmr.watchdog_reset_flag = 1'b0;
      end
      if (icr_read) begin
         next_s.tmr.capture_flag = 1'b0;
      end
      if (period_end) begin
         next_s.tmr.watchdog_refresh_bit = 1'b0;
         next_s.tmr.expired = !s.tmr.watchdog_refresh_bit;
      end
      // Writes to the capture flag and timebase flag are ignored; refresh is only ever set.
      if (csr_write) begin
         next_s.tmr.capture_irq_enable = s.bus.wdata[ltw_pkg::BIT_CAPTURE_IRQ_ENABLE];
         next_s.tmr.period_double_select = s.bus.wdata[ltw_pkg::BIT_PERIOD_DOUBLE_SELECT];
         next_s.tmr.timebase_irq_enable = s.bus.wdata[ltw_pkg::BIT_TIMEBASE_IRQ_ENABLE];
         next_s.tmr.watchdog_enable_bit = s.bus.wdata[ltw_pkg::BIT_WATCHDOG_ENABLE];
         if (s.bus.wdata[ltw_pkg::BIT_WATCHDOG_REFRESH]) begin
            next_s.tmr.watchdog_refresh_bit = 1'b1;
         end
      end
      if (tb_event) begin
         next_s.tmr.timebase_flag = 1'b1;
      end
      if (capture_take) begin
         next_s.tmr.capture_flag = 1'b1;
         next_s.tmr.capture_value = s.tmr.count[12:5];
      end

      // Halt without the reset-on-halt option stops the oscillator; an external interrupt restarts it after the wake-up delay.
      if (s.tmr.halted) begin
         if (ext_wake_i) begin
            next_s.tmr.halted = 1'b0;
            next_s.tmr.wake_wait = 1'b1;
            next_s.tmr.wake_count = wake_delay_long_i ? ltw_pkg::WAKE_LONG_LOAD : ltw_pkg::WAKE_SHORT_LOAD;
         end
      end else if (halt_i && !reset_on_halt_opt_i) begin
         next_s.tmr.halted = 1'b1;
      end else if (s.tmr.wake_wait) begin
         next_s.tmr.wake_count = 10'(s.tmr.wake_count - 10'h001);
         if (s.tmr.wake_count == 10'h000) begin
            next_s.tmr.wake_wait = 1'b0;
         end
      end

      // A watchdog reset clears the timer like a chip reset but leaves its flag set.
      if (s.wdg_reset) begin
         next_s.tmr = ltw_pkg::TMR_RESET;
         next_s.tmr.watchdog_reset_flag = 1'b1;
         next_s.wdg_pulse = 5'(s.wdg_pulse - 5'h01);
         next_s.wdg_reset = (s.wdg_pulse != 5'h00);
      end else if (wdg_trigger) begin
         next_s.wdg_reset = 1'b1;
         next_s.wdg_pulse = ltw_pkg::WDG_PULSE_LOAD;
      end

      // Interrupt requests follow the flags, each gated by its enable and the CPU mask.
      next_s.tb_irq = next_s.tmr.timebase_flag && next_s.tmr.timebase_irq_enable && !cpu_irq_mask_i;
      next_s.ic_irq = next_s.tmr.capture_flag && next_s.tmr.capture_irq_enable && !cpu_irq_mask_i;
   end

   // ==========================================================================
   // State register; a low clock enable freezes everything, bus included.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s <= STATE_RESET;
      end else if (clk_en_i) begin
         s <= next_s;
      end
   end

   assign axi_rsp_o = s.bus.rsp;
   assign tb_irq_o = s.tb_irq;
   assign ic_irq_o = s.ic_irq;
   assign watchdog_reset_o = s.wdg_reset;

   // ==========================================================================
   // Checks; cycles with the clock enable low are skipped.
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!reset_n_i || !clk_en_i);

   sequence s_wake_from_halt;
      s.tmr.halted && ext_wake_i && !s.wdg_reset;
   endsequence

   sequence s_force_write;
      csr_write && s.bus.wdata[ltw_pkg::BIT_WATCHDOG_RESET_FLAG] && wdg_active && !s.wdg_reset && !s.tmr.halted;
   endsequence

   a_count_wrap: assert property (overflow && !s.wdg_reset |=> s.tmr.count == 13'h0000)
      else $error("Counter did not wrap to zero after 1F3Fh.");
   a_count_step: assert property (counting && !overflow && !s.wdg_reset && !wdg_trigger
                                  |=> s.tmr.count == $past(s.tmr.count) + 13'h0001)
      else $error("Counter did not advance by one.");
   a_tb_flag_set: assert property (tb_event && !s.wdg_reset |=> s.tmr.timebase_flag)
      else $error("Timebase event did not set the timebase flag.");
   a_tb_double: assert property (overflow && s.tmr.period_double_select && !s.tmr.tb_half && !s.wdg_reset
                                 && !s.tmr.timebase_flag && !csr_write |=> !s.tmr.timebase_flag)
      else $error("Doubled period flagged on the first overflow.");
   a_csr_clear: assert property (csr_read && !tb_event && !s.wdg_reset |=> !s.tmr.timebase_flag)
      else $error("Status read did not clear the timebase flag.");
   a_tb_irq_gate: assert property (tb_irq_o |-> $past(!cpu_irq_mask_i) && s.tmr.timebase_irq_enable
                                   && s.tmr.timebase_flag)
      else $error("Timebase interrupt raised without flag, enable or open mask.");
   a_force_reset: assert property (s_force_write |=> watchdog_reset_o)
      else $error("Forced watchdog reset did not happen.");
   a_halt_reset: assert property (halt_reset && !s.wdg_reset |=> watchdog_reset_o)
      else $error("Halt with reset option did not reset.");
   a_reset_flag: assert property ($fell(watchdog_reset_o) |-> s.tmr.watchdog_reset_flag
                                  && !s.tmr.watchdog_enable_bit)
      else $error("Watchdog reset ended without its flag or with watchdog still enabled.");
   a_halt_frozen: assert property (s.tmr.halted && !ext_wake_i && !s.wdg_reset |=> $stable(s.tmr.count))
      else $error("Counter moved during halt.");
   a_wake_delay: assert property (s_wake_from_halt |=> (!counting && !s.wdg_reset) [*8])
      else $error("Counter resumed too early after wake-up.");
   a_capture_take: assert property (capture_take && !s.wdg_reset
                                    |=> s.tmr.capture_flag && s.tmr.capture_value == $past(s.tmr.count[12:5]))
      else $error("Capture did not latch counter bits 12:5.");
   a_capture_block: assert property (s.tmr.capture_flag && !s.wdg_reset |=> $stable(s.tmr.capture_value))
      else $error("Capture value changed while the capture flag was set.");
   a_icr_clear: assert property (icr_read && !capture_take && !s.wdg_reset |=> !s.tmr.capture_flag)
      else $error("Capture value read did not clear the capture flag.");

   // Interrupt requests and the flags behind them.
   a_ic_irq_gate: assert property (ic_irq_o |-> $past(!cpu_irq_mask_i) && s.tmr.capture_irq_enable
                                   && s.tmr.capture_flag)
      else $error("Capture interrupt raised without flag, enable or open mask.");
   a_tb_irq_set: assert property (tb_event && s.tmr.timebase_irq_enable && !csr_write && !cpu_irq_mask_i
                                  && !s.wdg_reset |=> tb_irq_o)
      else $error("Enabled timebase event did not request an interrupt.");
   a_flag_write: assert property (csr_write && !capture_take && !icr_read && !s.wdg_reset
                                  |=> s.tmr.capture_flag == $past(s.tmr.capture_flag))
      else $error("Status write changed the capture flag.");
   // The synchroniser must not report one pin change twice.
   a_pin_once: assert property (pin_edge |=> !pin_edge)
      else $error("One pin change gave two edges.");

   // Watchdog timing, option and halt behaviour.
   a_refresh_clear: assert property (period_end && !csr_write && !s.wdg_reset |=> !s.tmr.watchdog_refresh_bit)
      else $error("Refresh bit survived the end of a watchdog period.");
   a_unrefreshed: assert property (period_end && wdg_active && !s.tmr.watchdog_refresh_bit && !s.wdg_reset
                                   |=> watchdog_reset_o)
      else $error("Unrefreshed watchdog period ended without a reset.");
   a_late_enable: assert property (s.tmr.expired && wdg_active && !s.tmr.halted && !s.wdg_reset
                                   |=> watchdog_reset_o)
      else $error("Enabling after an expired period did not reset at once.");
   a_hw_active: assert property (hw_watchdog_opt_i && period_end && !s.tmr.watchdog_refresh_bit && !s.wdg_reset
                                 |=> watchdog_reset_o)
      else $error("Hardware watchdog option did not reset on an unrefreshed period.");
   a_halt_no_reset: assert property (s.tmr.halted && !s.wdg_reset |=> !watchdog_reset_o)
      else $error("Watchdog reset raised while halted.");
   // A watchdog reset leaves the timer as a chip reset does, flag aside.
   a_reset_clears: assert property (s.wdg_reset |=> s.tmr.count == 13'h0000 && !s.tmr.watchdog_enable_bit
                                    && s.tmr.watchdog_reset_flag)
      else $error("Watchdog reset did not return the timer to its reset state.");

endmodule : ltw_lite_timer

// File: hdl/ltw_pkg.sv
/*
 * Constants, register layout and carrier types for the small timebase, watchdog and input capture timer.
 * Assumes a single oscillator clock that is also the bus clock, and an AXI4-Lite master on the register side.
 */
package ltw_pkg;

   // ==========================================================================
   // Register map: printed offsets are register indices, byte address is four times the index.
   localparam int ADDR_W = 8;
   localparam logic [7:0] CSR_INDEX = 8'h0B;
   localparam logic [7:0] ICR_INDEX = 8'h0C;
   localparam logic [ADDR_W-1:0] CSR_ADDR = ADDR_W'({CSR_INDEX, 2'b00});
   localparam logic [ADDR_W-1:0] ICR_ADDR = ADDR_W'({ICR_INDEX, 2'b00});

   // ==========================================================================
   // Status/control field positions.
   localparam int BIT_CAPTURE_IRQ_ENABLE = 7;
   localparam int BIT_CAPTURE_FLAG = 6;
   localparam int BIT_PERIOD_DOUBLE_SELECT = 5;
   localparam int BIT_TIMEBASE_IRQ_ENABLE = 4;
   localparam int BIT_TIMEBASE_FLAG = 3;
   localparam int BIT_WATCHDOG_RESET_FLAG = 2;
   localparam int BIT_WATCHDOG_ENABLE = 1;
   localparam int BIT_WATCHDOG_REFRESH = 0;

   // ==========================================================================
   // Reset values and timing counts in oscillator clocks.
   localparam logic [7:0] CSR_RESET = 8'h00;
   localparam logic [7:0] ICR_RESET = 8'h00;
   localparam logic [12:0] COUNT_WRAP = 13'h1F3F;
   localparam int WAKE_SHORT_CYCLES = 256;
   localparam int WAKE_LONG_CYCLES = 512;
   localparam logic [9:0] WAKE_SHORT_LOAD = 10'(WAKE_SHORT_CYCLES - 1);
   localparam logic [9:0] WAKE_LONG_LOAD = 10'(WAKE_LONG_CYCLES - 1);
   localparam logic [4:0] WDG_PULSE_LOAD = 5'h0F;

   // ==========================================================================
   // Bus answers and decode results.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {
      LTW_SEL_NONE = 2'b00,
      LTW_SEL_CSR = 2'b01,
      LTW_SEL_ICR = 2'b10
   } ltw_sel_t;

   // ==========================================================================
   // AXI4-Lite carriers, signal names as published.
   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic [2:0] awprot;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic [2:0] arprot;
      logic rready;
   } ltw_axi_req_t;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } ltw_axi_rsp_t;

   // ==========================================================================
   // Timer state, cleared by chip reset, and by a watchdog reset except for the watchdog reset flag.
   typedef struct packed {
      logic [12:0] count;
      logic tb_half;
      logic wdg_half;
      logic expired;
      logic capture_irq_enable;
      logic capture_flag;
      logic period_double_select;
      logic timebase_irq_enable;
      logic timebase_flag;
      logic watchdog_reset_flag;
      logic watchdog_enable_bit;
      logic watchdog_refresh_bit;
      logic [7:0] capture_value;
      logic halted;
      logic wake_wait;
      logic [9:0] wake_count;
   } ltw_tmr_t;

   // Bus slave state, kept across a watchdog reset so a transfer in flight still ends.
   typedef struct packed {
      logic aw_held;
      logic w_held;
      logic [ADDR_W-1:0] awaddr;
      logic [7:0] wdata;
      logic wstrb0;
      ltw_axi_rsp_t rsp;
   } ltw_bus_t;

   typedef struct packed {
      ltw_tmr_t tmr;
      ltw_bus_t bus;
      logic [2:0] pin_sync;
      logic pin_level;
      logic wdg_reset;
      logic [4:0] wdg_pulse;
      logic tb_irq;
      logic ic_irq;
   } ltw_state_t;

   localparam ltw_tmr_t TMR_RESET = '{default: '0};

endpackage : ltw_pkg

// File: test/tb_ltw_lite_timer.sv
/*
 * Self-checking bench for ltw_lite_timer: register bus, capture, timebase and watchdog.
 * Assumes ltw_pkg and the design are compiled first; the bench is the only bus master.
 */
module tb_ltw_lite_timer;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] CSR = ltw_pkg::CSR_ADDR;
   localparam logic [7:0] ICR = ltw_pkg::ICR_ADDR;
   logic clk_i = 1'b0;
   logic reset_n_i = 1'b0;
   logic pin = 1'b0;
   logic halt = 1'b0;
   logic mask = 1'b0;
   logic hw_opt = 1'b0;
   logic roh = 1'b0;
   logic wake = 1'b0;
   logic wlong = 1'b0;
   logic en = 1'b1;
   ltw_pkg::ltw_axi_req_t req = '0;
   ltw_pkg::ltw_axi_rsp_t rsp;
   logic tb_irq;
   logic ic_irq;
   logic wdg_rst;
   int num_errors = 0;
   int n_tests = 0;
   int cyc = 0;
   int n;
   int c;
   longint t1;
   logic [12:0] model_cnt = 13'h0000;
   logic [31:0] d;
   logic [1:0] r;

   // Every input is driven; the halt test also drops the clock enable during the wake-up delay.
   ltw_lite_timer uut (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(en), .axi_req_i(req), .axi_rsp_o(rsp),
      .capture_input_pin_i(pin), .halt_i(halt), .ext_wake_i(wake), .cpu_irq_mask_i(mask),
      .hw_watchdog_opt_i(hw_opt), .reset_on_halt_opt_i(roh), .wake_delay_long_i(wlong),
      .tb_irq_o(tb_irq), .ic_irq_o(ic_irq), .watchdog_reset_o(wdg_rst));

   // ==========================================================================
   // Clock, counter model and hang guard.
   always #10 clk_i = ~clk_i;
   always @(posedge clk_i) begin
      cyc <= cyc + 1;
      model_cnt <= (!reset_n_i || model_cnt == 13'h1F3F) ? 13'h0000 : model_cnt + 13'h0001;
      if (cyc == 95000) begin
         num_errors++;
         stop_test();
      end
   end

   // ==========================================================================
   // Report, compare and bus tasks.
   task automatic stop_test();
      $display("tests %0d mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : stop_test

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      n_tests++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask : chk

   // Expected capture value: the upper eight bits of a counter value.
   function automatic logic [31:0] cap_of(input int cnt);
      return 32'(cnt[12:5]);
   endfunction : cap_of

   // Address and data are offered together and each is dropped once taken.
   // Response ready stays high between transfers, so back-to-back calls never drive it twice in one step.
   task automatic wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
      req.awvalid <= 1'b1;
      req.awaddr <= a;
      req.wvalid <= 1'b1;
      req.wdata <= v;
      req.wstrb <= 4'hF;
      req.bready <= 1'b1;
      forever begin
         @(posedge clk_i);
         if (rsp.awready) req.awvalid <= 1'b0;
         if (rsp.wready) req.wvalid <= 1'b0;
         if (rsp.bvalid) begin
            resp = rsp.bresp;
            break;
         end
      end
   endtask : wr

   task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
      req.arvalid <= 1'b1;
      req.araddr <= a;
      req.rready <= 1'b1;
      forever begin
         @(posedge clk_i);
         if (rsp.arready) req.arvalid <= 1'b0;
         if (rsp.rvalid) begin
            v = rsp.rdata;
            resp = rsp.rresp;
            break;
         end
      end
   endtask : rd

   // Waits a bounded number of edges for: 0 timebase irq, 1 capture irq, 2 reset high, 3 reset low.
   task automatic wait_for(input int which, input int max, output int cnt);
      logic [3:0] s;
      cnt = 0;
      do begin
         @(posedge clk_i);
         cnt++;
         s = {wdg_rst === 1'b0, wdg_rst === 1'b1, ic_irq === 1'b1, tb_irq === 1'b1};
      end while (!s[which] && cnt < max);
   endtask : wait_for

   // ==========================================================================
   // Main sequence.
   initial begin
      void'($urandom(32'hA0DA8F51));
      repeat (5) @(posedge clk_i);
      reset_n_i <= 1'b1;
      @(posedge clk_i);
      wr(8'h40, $urandom(), r);
      chk("unmapped write resp", 32'(ltw_pkg::RESP_SLVERR), 32'(r));
      rd(8'h40, d, r);
      chk("unmapped read resp", 32'(ltw_pkg::RESP_SLVERR), 32'(r));
      chk("unmapped read data", 32'h00000000, d);
      rd(CSR, d, r);
      chk("status reset value", 32'h00000000, d);
      rd(ICR, d, r);
      chk("capture reset value", 32'h00000000, d);
      $display("test bus done");
      // A rising edge captures, a falling edge under a set flag is blocked.
      wr(CSR, 32'h00000080, r);
      repeat ($urandom_range(200, 5000)) @(posedge clk_i);
      pin <= 1'b1;
      c = int'(model_cnt);
      wait_for(1, 12, n);
      chk("capture irq", 32'h00000001, 32'(ic_irq));
      pin <= 1'b0;
      repeat (10) @(posedge clk_i);
      rd(ICR, d, r);
      chk("capture value window", 32'h00000001, 32'(d >= cap_of(c + 2) && d <= cap_of(c + 6)));
      wr(CSR, 32'h000000C0, r);
      rd(CSR, d, r);
      chk("capture flag kept clear", 32'h00000080, d);
      chk("capture irq cleared", 32'h00000000, 32'(ic_irq));
      pin <= 1'b1;
      wait_for(1, 12, n);
      chk("capture after clear", 32'h00000001, 32'(ic_irq));
      rd(ICR, d, r);
      $display("test capture done");
      // Timebase period, flag, read clear and the CPU mask.
      wr(CSR, 32'h00000010, r);
      rd(CSR, d, r);
      wait_for(0, 8100, n);
      t1 = $time;
      rd(CSR, d, r);
      chk("timebase flag", 32'h00000018, d);
      repeat (2) @(posedge clk_i);
      chk("timebase irq cleared", 32'h00000000, 32'(tb_irq));
      wait_for(0, 8100, n);
      chk("timebase period", 32'd8000, 32'(($time - t1) / 20));
      mask <= 1'b1;
      rd(CSR, d, r);
      wait_for(0, 8100, n);
      chk("masked irq", 32'h00000000, 32'(tb_irq));
      rd(CSR, d, r);
      chk("flag while masked", 32'h00000018, d);
      mask <= 1'b0;
      wr(CSR, 32'h00000030, r);
      rd(CSR, d, r);
      wait_for(0, 16100, n);
      t1 = $time;
      rd(CSR, d, r);
      wait_for(0, 16100, n);
      chk("double period", 32'd16000, 32'(($time - t1) / 20));
      $display("test timebase done");
      // Late enable after unrefreshed periods resets at once.
      wr(CSR, 32'h00000002, r);
      wait_for(2, 6, n);
      chk("late enable reset", 32'h00000001, 32'(wdg_rst));
      wait_for(3, 40, n);
      rd(CSR, d, r);
      chk("watchdog reset flag", 32'h00000004, d);
      rd(CSR, d, r);
      chk("reset flag cleared", 32'h00000000, d);
      // Halt and wake with a refreshed watchdog; the clock enable also stalls the wake-up count.
      wlong <= 1'($urandom_range(0, 1));
      wr(CSR, 32'h00000013, r);
      chk("status write resp", 32'(ltw_pkg::RESP_OKAY), 32'(r));
      wait_for(0, 8100, n);
      t1 = $time;
      rd(CSR, d, r);
      wr(CSR, 32'h00000013, r);
      halt <= 1'b1;
      @(posedge clk_i);
      halt <= 1'b0;
      c = $urandom_range(20, 300);
      repeat (c) @(posedge clk_i);
      wake <= 1'b1;
      @(posedge clk_i);
      wake <= 1'b0;
      en <= 1'b0;
      n = $urandom_range(3, 40);
      c += n;
      repeat (n) @(posedge clk_i);
      en <= 1'b1;
      c += wlong ? ltw_pkg::WAKE_LONG_CYCLES : ltw_pkg::WAKE_SHORT_CYCLES;
      wait_for(0, 9000, n);
      chk("halt wake period", 32'(8001 + c), 32'(($time - t1) / 20));
      chk("no reset through halt", 32'h00000000, 32'(wdg_rst));
      $display("test halt done");
      wr(CSR, 32'h00000002, r);
      wr(CSR, 32'h00000006, r);
      wait_for(2, 6, n);
      chk("forced reset", 32'h00000001, 32'(wdg_rst));
      wait_for(3, 40, n);
      rd(CSR, d, r);
      hw_opt <= 1'b1;
      t1 = $time;
      wait_for(2, 16100, n);
      chk("hw watchdog timeout", 32'h00000001, 32'(($time - t1) / 20 > 15900 && n < 16100));
      hw_opt <= 1'b0;
      wait_for(3, 40, n);
      roh <= 1'b1;
      halt <= 1'b1;
      @(posedge clk_i);
      halt <= 1'b0;
      wait_for(2, 3, n);
      chk("reset on halt", 32'h00000001, 32'(wdg_rst));
      $display("test watchdog done");
      stop_test();
   end
endmodule : tb_ltw_lite_timer
